/* logic/nvc_pkg.sv */
// package: constants and carrier types for the nonvolatile byte controller
`default_nettype none
package nvc_pkg;
   // direct special function register addresses (sector independent)
   localparam logic [7:0] SFR_INDIRECT_ONE = 8'h02;
   localparam logic [7:0] SFR_PTR_ONE_LOW = 8'h03;
   localparam logic [7:0] SFR_PTR_ONE_HIGH = 8'h04;
   localparam logic [7:0] SFR_INDIRECT_TWO = 8'h05;
   localparam logic [7:0] SFR_PTR_TWO_LOW = 8'h06;
   localparam logic [7:0] SFR_PTR_TWO_HIGH = 8'h07;
   localparam logic [7:0] SFR_BYTE_INDEX = 8'h2a;
   localparam logic [7:0] SFR_BYTE_VALUE = 8'h2b;

   // control register location behind the indirect ports
   localparam logic [7:0] CTRL_SECTOR = 8'h01;
   localparam logic [7:0] CTRL_OFFSET = 8'h40;

   // control register field positions
   localparam int CTRL_READ_TRIG = 0;
   localparam int CTRL_READ_PERMIT = 1;
   localparam int CTRL_PROG_TRIG = 2;
   localparam int CTRL_PROG_PERMIT = 3;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_PTR = 8'h00;

   // array size of the largest variant
   localparam int ARRAY_ADDR_W = 8;

   // programming time of the internal timer
   localparam int CLK_PERIOD_NS = 20;
   localparam int PROG_TIME_NS = 4000;
   localparam int PROG_CYCLES = (PROG_TIME_NS / CLK_PERIOD_NS < 1) ?
                                1 : PROG_TIME_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } nvc_sfr_req_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_PROG = 3'b100
   } nvc_state_t;
endpackage
`default_nettype wire

/* logic/nvc_array.sv */
// module: byte-wide nonvolatile array model with registered read data
`default_nettype none
module nvc_array #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   import nvc_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
   } nvc_arr_st_t;

   // cell contents are not reset: they must survive a reset
   logic [7:0] cells [0:(1<<ADDR_W)-1];
   nvc_arr_st_t st_ff;
   nvc_arr_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (rd_en) begin
         nxt_st.rdata = cells[addr];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         cells[addr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata = st_ff.rdata;
endmodule
`default_nettype wire

/* logic/nvc_prog_timer.sv */
// module: self-timed programming interval counter
`default_nettype none
module nvc_prog_timer #(
   parameter int CYCLES = 200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   import nvc_pkg::*;

   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   typedef struct packed {
      logic busy;
      logic [CNT_W-1:0] cnt;
   } nvc_tmr_st_t;

   nvc_tmr_st_t st_ff;
   nvc_tmr_st_t nxt_st;

   // the timer free-runs from start; the core cannot stretch or abort it
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.busy) begin
         if (st_ff.cnt == LAST) begin
            nxt_st.busy = 1'b0;
            nxt_st.cnt = '0;
         end else begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
         end
      end else if (start) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = st_ff.busy;
   assign done = st_ff.busy && (st_ff.cnt == LAST);
endmodule
`default_nettype wire

/* logic/nvc_ctrl.sv */
// module: data nonvolatile byte access controller seen from the core
`default_nettype none
module nvc_ctrl #(
   parameter int ADDR_W = nvc_pkg::ARRAY_ADDR_W,
   parameter int PROG_CYCLES = nvc_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire nvc_pkg::nvc_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic nv_done_flag_clr,
   input wire logic mf_irq_ack,
   input wire logic nv_done_irq_enable,
   output logic nv_done_flag,
   output logic mf_irq_flag,
   output logic nv_irq_req,
   output logic nv_busy
);
   import nvc_pkg::*;

   // mask of implemented index bits for this variant
   // applied on write and again on read, so every variant shares
   // one register body with no special case
   localparam logic [7:0] IDX_MASK = 8'((1 << ADDR_W) - 1);

   typedef struct packed {
      nvc_state_t state;
      logic [7:0] ptr_one_low;
      logic [7:0] ptr_one_high;
      logic [7:0] ptr_two_low;
      logic [7:0] ptr_two_high;
      logic [7:0] byte_index;
      logic [7:0] byte_value;
      logic program_permit;
      logic prog_trig;
      logic read_permit;
      logic read_trig;
      logic [ADDR_W-1:0] cap_index;
      logic [7:0] cap_value;
      logic done_flag;
      logic mf_flag;
      logic [7:0] rdata;
   } nvc_st_t;

   nvc_st_t st_ff;
   nvc_st_t nxt_st;

   logic [1:0][7:0] port_low;
   logic [1:0][7:0] port_high;
   logic [1:0][7:0] port_sfr;
   logic [1:0] port_hit;
   logic [1:0] port_sel;
   logic cycle_free;
   logic ctrl_wr;
   logic ctrl_rd;
   logic [7:0] ctrl_view;
   logic start_prog;
   logic start_read;
   logic arr_rd_en;
   logic arr_wr_en;
   logic [ADDR_W-1:0] arr_addr;
   logic [7:0] arr_rdata;
   logic tmr_busy;
   logic tmr_done;

   // both indirect ports decode alike, so either can reach the control
   // register; a pointer aimed anywhere else sees an empty location
   assign port_low = {st_ff.ptr_two_low, st_ff.ptr_one_low};
   assign port_high = {st_ff.ptr_two_high, st_ff.ptr_one_high};
   assign port_sfr = {SFR_INDIRECT_TWO, SFR_INDIRECT_ONE};

   for (genvar p = 0; p < 2; p++) begin : g_port
      // control register is visible only through a pointer aimed at it
      assign port_hit[p] = (port_high[p] == CTRL_SECTOR) &&
                           (port_low[p] == CTRL_OFFSET);
      assign port_sel[p] = (sfr_req.addr == port_sfr[p]) && port_hit[p];
   end

   // reads decode the port alone; the read strobe qualifies them later
   assign ctrl_rd = |port_sel;
   assign ctrl_wr = sfr_req.wr && ctrl_rd;

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[CTRL_PROG_PERMIT] = st_ff.program_permit;
      ctrl_view[CTRL_PROG_TRIG] = st_ff.prog_trig;
      ctrl_view[CTRL_READ_PERMIT] = st_ff.read_permit;
      ctrl_view[CTRL_READ_TRIG] = st_ff.read_trig;
   end

   // a new cycle needs both the sequencer and the timer at rest
   assign cycle_free = (st_ff.state == ST_IDLE) && !tmr_busy;

   // permits are judged on their stored value, so a write that sets a
   // permit and its trigger together starts nothing
   assign start_prog = ctrl_wr && sfr_req.wdata[CTRL_PROG_TRIG] &&
                       st_ff.program_permit &&
                       cycle_free;
   // if both triggers arrive together, programming takes precedence
   assign start_read = ctrl_wr && sfr_req.wdata[CTRL_READ_TRIG] &&
                       st_ff.read_permit &&
                       cycle_free && !start_prog;

   // one byte per access; a read start addresses the array from byte_index, a program uses only captured values
   assign arr_rd_en = start_read;
   assign arr_addr = start_read ? ADDR_W'(st_ff.byte_index) :
                     st_ff.cap_index;
   // the cell changes only on the last timer count, so a reset in
   // mid-cycle leaves the old byte in place
   assign arr_wr_en = (st_ff.state == ST_PROG) && tmr_done;

   always_comb begin
      nxt_st = st_ff;

      // direct registers answer whatever the pointers hold
      if (sfr_req.wr) begin
         unique case (sfr_req.addr)
            SFR_PTR_ONE_LOW: begin
               nxt_st.ptr_one_low = sfr_req.wdata;
            end
            SFR_PTR_ONE_HIGH: begin
               nxt_st.ptr_one_high = sfr_req.wdata;
            end
            SFR_PTR_TWO_LOW: begin
               nxt_st.ptr_two_low = sfr_req.wdata;
            end
            SFR_PTR_TWO_HIGH: begin
               nxt_st.ptr_two_high = sfr_req.wdata;
            end
            SFR_BYTE_INDEX: begin
               nxt_st.byte_index = sfr_req.wdata & IDX_MASK;
            end
            SFR_BYTE_VALUE: begin
               nxt_st.byte_value = sfr_req.wdata;
            end
            default: begin
            end
         endcase
      end

      // permits are plain read/write bits; triggers only set here
      // a permit cleared mid-cycle does not stop a running cycle
      if (ctrl_wr) begin
         nxt_st.program_permit = sfr_req.wdata[CTRL_PROG_PERMIT];
         nxt_st.read_permit = sfr_req.wdata[CTRL_READ_PERMIT];
      end

      // one cycle at a time: triggers are honoured only when idle
      unique case (st_ff.state)
         ST_IDLE: begin
            if (start_prog) begin
               nxt_st.prog_trig = 1'b1;
               nxt_st.cap_index = ADDR_W'(st_ff.byte_index);
               nxt_st.cap_value = st_ff.byte_value;
               nxt_st.state = ST_PROG;
            end else if (start_read) begin
               nxt_st.read_trig = 1'b1;
               nxt_st.cap_index = ADDR_W'(st_ff.byte_index);
               nxt_st.state = ST_READ;
            end
         end
         ST_READ: begin
            // array data registered on the start edge is ready now
            nxt_st.byte_value = arr_rdata;
            nxt_st.read_trig = 1'b0;
            nxt_st.state = ST_IDLE;
         end
         ST_PROG: begin
            // trigger stays set until the last count, for software polls
            if (tmr_done) begin
               nxt_st.prog_trig = 1'b0;
               nxt_st.state = ST_IDLE;
            end
         end
      endcase

      // a set in the same cycle as a clear wins, so no end is lost
      if (nv_done_flag_clr) begin
         nxt_st.done_flag = 1'b0;
      end
      if (mf_irq_ack) begin
         nxt_st.mf_flag = 1'b0;
      end
      if (arr_wr_en) begin
         nxt_st.done_flag = 1'b1;
         nxt_st.mf_flag = 1'b1;
      end

      // read data path is registered: answer one cycle after the request
      nxt_st.rdata = 8'h00;
      if (sfr_req.rd) begin
         if (ctrl_rd) begin
            nxt_st.rdata = ctrl_view;
         end else begin
            unique case (sfr_req.addr)
               SFR_PTR_ONE_LOW: begin
                  nxt_st.rdata = st_ff.ptr_one_low;
               end
               SFR_PTR_ONE_HIGH: begin
                  nxt_st.rdata = st_ff.ptr_one_high;
               end
               SFR_PTR_TWO_LOW: begin
                  nxt_st.rdata = st_ff.ptr_two_low;
               end
               SFR_PTR_TWO_HIGH: begin
                  nxt_st.rdata = st_ff.ptr_two_high;
               end
               SFR_BYTE_INDEX: begin
                  nxt_st.rdata = st_ff.byte_index & IDX_MASK;
               end
               SFR_BYTE_VALUE: begin
                  nxt_st.rdata = st_ff.byte_value;
               end
               default: begin
                  nxt_st.rdata = 8'h00;
               end
            endcase
         end
      end
   end

   // power-on: permits, triggers and pointers all cleared
   // array cells keep their bytes; only the access state is cleared
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.state <= ST_IDLE;
         st_ff.ptr_one_low <= RST_PTR;
         st_ff.ptr_one_high <= RST_PTR;
         st_ff.ptr_two_low <= RST_PTR;
         st_ff.ptr_two_high <= RST_PTR;
         st_ff.byte_index <= RST_BYTE;
         st_ff.byte_value <= RST_BYTE;
         st_ff.program_permit <= 1'b0;
         st_ff.prog_trig <= 1'b0;
         st_ff.read_permit <= 1'b0;
         st_ff.read_trig <= 1'b0;
         st_ff.cap_index <= '0;
         st_ff.cap_value <= RST_BYTE;
         st_ff.done_flag <= 1'b0;
         st_ff.mf_flag <= 1'b0;
         st_ff.rdata <= RST_BYTE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   nvc_array #(
      .ADDR_W(ADDR_W)
   ) u_array (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(arr_wr_en),
      .rd_en(arr_rd_en),
      .addr(arr_addr),
      .wdata(st_ff.cap_value),
      .rdata(arr_rdata)
   );

   // self-timed interval; the core clock only counts it out
   nvc_prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(start_prog),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   assign sfr_rdata = st_ff.rdata;
   assign nv_done_flag = st_ff.done_flag;
   assign mf_irq_flag = st_ff.mf_flag;
   // servicing the shared flag alone is enough to drop the request
   assign nv_irq_req = st_ff.mf_flag && st_ff.done_flag &&
                       nv_done_irq_enable;
   // lets the power manager hold off idle while a cycle runs
   assign nv_busy = st_ff.read_trig || st_ff.prog_trig || tmr_busy;
endmodule
`default_nettype wire

/* verif/nvc_ctrl_sva.sv */
// checker: port assertions for the nonvolatile byte controller
`default_nettype none
module nvc_ctrl_sva #(
   parameter int ADDR_W = 8,
   parameter int PROG_CYCLES = 200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire nvc_pkg::nvc_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic nv_done_flag_clr,
   input wire logic mf_irq_ack,
   input wire logic nv_done_irq_enable,
   input wire logic nv_done_flag,
   input wire logic mf_irq_flag,
   input wire logic nv_irq_req,
   input wire logic nv_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   import nvc_pkg::*;
   // slack of two covers the trigger and clear edges around the timer
   localparam int BUSY_MAX = PROG_CYCLES + 2;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle_zero: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
      else $error("read data not zero without a read");
   a_unmapped_read: assert property (sfr_req.rd && sfr_req.addr == 8'h10
      |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   a_index_upper_zero: assert property (sfr_req.rd &&
      sfr_req.addr == SFR_BYTE_INDEX |=> (16'(sfr_rdata) >> ADDR_W) == 16'h0000)
      else $error("unimplemented index bits not zero");
   a_irq_req_and: assert property (nv_irq_req ==
      (mf_irq_flag & nv_done_flag & nv_done_irq_enable))
      else $error("interrupt request not the and of its flags");
   a_done_flag_sticky: assert property (nv_done_flag && !nv_done_flag_clr
      |=> nv_done_flag) else $error("done flag dropped without clear");
   a_mf_flag_sticky: assert property (mf_irq_flag && !mf_irq_ack
      |=> mf_irq_flag) else $error("shared flag dropped without service");
   a_flags_set_together: assert property ($rose(nv_done_flag) |->
      mf_irq_flag) else $error("done flag set without shared flag");
   a_done_after_busy: assert property ($rose(nv_done_flag) |->
      $past(nv_busy) && !nv_busy) else $error("done flag without a cycle end");
   a_busy_bounded: assert property ($rose(nv_busy) |->
      ##[1:BUSY_MAX] !nv_busy) else $error("cycle ran too long");
endmodule
bind nvc_ctrl nvc_ctrl_sva #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_sva (
   .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .nv_done_flag_clr(nv_done_flag_clr), .mf_irq_ack(mf_irq_ack),
   .nv_done_irq_enable(nv_done_irq_enable), .nv_done_flag(nv_done_flag),
   .mf_irq_flag(mf_irq_flag), .nv_irq_req(nv_irq_req), .nv_busy(nv_busy));
`default_nettype wire

/* verif/nvc_core_model.sv */
// partner: core side master issuing single register accesses
`default_nettype none
module nvc_core_model (
   input wire logic clk,
   output var nvc_pkg::nvc_sfr_req_t sfr_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import nvc_pkg::*;
   // one access at a time, the core never sleeps mid-cycle
   initial sfr_req = '0;
   // released lines carry the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
      @(posedge clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
   endtask
endmodule
`default_nettype wire

/* verif/nvc_ctrl_tb.sv */
// testbench: register level scenarios for the nonvolatile byte controller
`default_nettype none
module nvc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import nvc_pkg::*;
   logic clk, rst_n, clr, ack, en, done, mf, irq, busy, rd_seen;
   nvc_sfr_req_t req;
   logic [7:0] rdata, a, d;
   logic [7:0] q[$];
   logic [7:0] mem [64];
   int err_count, num_checks, seed, i;

   nvc_core_model u_core (.clk(clk), .sfr_req(req));
   nvc_ctrl #(.ADDR_W(6), .PROG_CYCLES(8)) u_dut (.clk(clk), .rst_n(rst_n),
      .sfr_req(req), .sfr_rdata(rdata), .nv_done_flag_clr(clr),
      .mf_irq_ack(ack), .nv_done_irq_enable(en), .nv_done_flag(done),
      .mf_irq_flag(mf), .nv_irq_req(irq), .nv_busy(busy));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rc(input logic [7:0] ad, input logic [7:0] e);
      q.push_back(e);
      u_core.rd(ad);
   endtask
   // read data stands one cycle, so it is taken mid-cycle
   always @(posedge clk) rd_seen <= req.rd;
   always @(negedge clk) begin
      if (rd_seen) chk(rdata, q.pop_front());
   end
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge clk);
      while (busy !== 1'b0) begin
         @(negedge clk);
         n++;
         if (n > 50) begin
            err_count++;
            stop_test();
         end
      end
   endtask
   task automatic pulse_chk(input logic c, input logic [7:0] e);
      @(posedge clk);
      clr <= c;
      ack <= ~c;
      @(posedge clk);
      clr <= 1'b0;
      ack <= 1'b0;
      @(negedge clk);
      chk({5'h00, irq, mf, done}, e);
   endtask
   task automatic prog(input logic [7:0] ad, input logic [7:0] v);
      u_core.wr(SFR_BYTE_INDEX, ad);
      u_core.wr(SFR_BYTE_VALUE, v);
      // done interrupt masked while permit and trigger go in
      en <= 1'b0;
      u_core.wr(SFR_INDIRECT_ONE, 8'h08);
      u_core.wr(SFR_INDIRECT_ONE, 8'h0c);
      en <= v[0];
      mem[ad[5:0]] = v;
      // index moved mid-cycle must not steer the write
      u_core.wr(SFR_BYTE_INDEX, ad ^ 8'h3f);
      rc(SFR_INDIRECT_ONE, 8'h0c);
      @(negedge clk);
      chk({7'h00, busy}, 8'h01);
      wait_idle();
      rc(SFR_INDIRECT_ONE, 8'h08);
      wait_idle();
      chk({5'h00, irq, mf, done}, {5'h00, v[0], 2'b11});
      pulse_chk(1'b1, 8'h02);
      pulse_chk(1'b0, 8'h00);
   endtask
   task automatic rdarr(input logic [7:0] ad);
      u_core.wr(SFR_BYTE_INDEX, ad);
      u_core.wr(SFR_INDIRECT_ONE, 8'h02);
      u_core.wr(SFR_INDIRECT_ONE, 8'h03);
      wait_idle();
      rc(SFR_INDIRECT_ONE, 8'h02);
      rc(SFR_BYTE_VALUE, mem[ad[5:0]]);
      rc(SFR_BYTE_VALUE, mem[ad[5:0]]);
   endtask

   initial begin
      seed = 34448;
      err_count = 0;
      num_checks = 0;
      rst_n = 1'b0;
      clr = 1'b0;
      ack = 1'b0;
      en = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 2; i < 8; i++) rc(8'(i), 8'h00);
      rc(SFR_BYTE_INDEX, 8'h00);
      rc(SFR_BYTE_VALUE, 8'h00);
      u_core.wr(SFR_INDIRECT_ONE, 8'h08);
      rc(8'h10, 8'h00);
      u_core.wr(SFR_BYTE_INDEX, 8'hff);
      rc(SFR_BYTE_INDEX, 8'h3f);
      u_core.wr(SFR_PTR_ONE_LOW, CTRL_OFFSET);
      u_core.wr(SFR_PTR_ONE_HIGH, CTRL_SECTOR);
      rc(SFR_INDIRECT_ONE, 8'h00);
      // permit and trigger in one write: permit stored, no cycle
      u_core.wr(SFR_INDIRECT_ONE, 8'hfc);
      rc(SFR_INDIRECT_ONE, 8'h08);
      u_core.wr(SFR_BYTE_VALUE, 8'ha5);
      u_core.wr(SFR_INDIRECT_ONE, 8'h03);
      repeat (4) @(posedge clk);
      rc(SFR_BYTE_VALUE, 8'ha5);
      rc(SFR_INDIRECT_ONE, 8'h02);
      for (i = 0; i < 6; i++) begin
         a = 8'($random(seed)) & 8'h3f;
         a = (i == 0) ? 8'h00 : (i == 5) ? 8'h3f : a;
         d = 8'($random(seed));
         prog(a, d);
         rdarr(a);
      end
      u_core.wr(SFR_PTR_TWO_LOW, CTRL_OFFSET);
      u_core.wr(SFR_PTR_TWO_HIGH, CTRL_SECTOR);
      rc(SFR_INDIRECT_TWO, 8'h02);
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule
`default_nettype wire
